// File: logic/mamc_pkg.sv
// Package for the mirror-array mode control block: register map, field
// positions, timing constants, modes, commands and carrier structs.
// Assumes a 50 MHz system clock shared by every user of the package.
package mamc_pkg;

  // Clock rate and the times derived from it
  localparam int CLK_MHZ = 50;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int WDOG_MS = 1000;
  localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
  localparam int PATTERN_MS = 100;
  localparam int PATTERN_CYC = PATTERN_MS * 1000 * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OVERRIDE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_WDOG_KICK = 8'h10;
  localparam logic [7:0] OFS_LED = 8'h14;

  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] OVERRIDE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [1:0] LED_ON_RESET = 2'h0;

  // Field positions
  localparam int CTRL_OVR_EN = 0;
  localparam int CTRL_ATYPE_LO = 1;
  localparam int STAT_BUSY = 8;
  localparam int STAT_WAIT = 9;
  localparam int STAT_PARK = 10;
  localparam int STAT_DROPPED = 11;

  // Function switch positions, switch 1 at bit 0
  localparam int SW_PARK = 0;
  localparam int SW_HALT = 1;
  localparam int SW_COMPLEMENT = 2;
  localparam int SW_FLIP = 3;
  localparam int SW_RTYPE_LO = 4;
  localparam int SW_ROW_ADDR = 6;
  localparam int SW_WDOG = 7;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RT_SINGLE = 2'h0,
    RT_DUAL = 2'h1,
    RT_GLOBAL = 2'h2,
    RT_QUAD = 2'h3
  } mamc_rst_type_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LOAD = 3'h1,
    OP_LOAD_RESET = 3'h2,
    OP_RESET = 3'h3,
    OP_CLEAR = 3'h4,
    OP_CLEAR_RESET = 3'h5,
    OP_FLOAT = 3'h6,
    OP_WAIT_EXT = 3'h7
  } mamc_op_e;

  // Array geometry: last block index and rows per block
  localparam logic [1:0] AT_1080 = 2'h0;
  localparam logic [1:0] AT_768 = 2'h1;
  localparam logic [3:0] LAST_BLK_15 = 4'hE;
  localparam logic [3:0] LAST_BLK_16 = 4'hF;
  localparam logic [6:0] ROWS_1080 = 7'h48;
  localparam logic [6:0] ROWS_768 = 7'h30;
  localparam logic [6:0] ROWS_800 = 7'h32;

  typedef struct packed {
    logic park;
    logic halt;
    logic complement;
    logic ns_flip;
    mamc_rst_type_e reset_type;
    logic row_addr;
    logic wdog_en;
  } mamc_mode_s;

  typedef struct packed {
    logic write_data;
    logic clear_data;
    logic mirror_clock;
    logic global;
    logic [3:0] block;
    logic [6:0] rows;
  } mamc_blk_op_s;

endpackage

// File: logic/mamc_top.sv
// Mirror-array mode control: switch and button conditioning, mode outputs,
// block image command sequencer, watchdog, LEDs and an AXI4-Lite slave.
// Assumes all pins but the switches and buttons are synchronous to aclk and the partner accepts block
// operations through a valid/ready pair.
`timescale 1ns/1ps

// Notes on behaviour
// - Switch 1 on parks every mirror flat.
// - Switch 2 on freezes the test pattern counter.
// - Switch 3 on complements all forwarded data.
// - Switch 4 on reverses row loading order.
// - Switches 6 and 5 select reset type.
// - Switch 7 on selects row address mode.
// - Switch 8 enables watchdog, blocks other resets.
// - Reset button resets logic and array side.
// - Park button press forces mirrors parked.
// - Ready LED driven high once configured.
// - User LEDs light when driven low.
// - Load writes blocks without changing mirrors.
// - Load-and-reset writes blocks then displays them.
// - Reset pulses mirror clock, block or global.
// - Clear zeroes blocks; clear-and-reset also displays.
// - Rows per block follow array type.
// - One block or whole image per command.
// - Host override replaces switch bank values.
// - Wait command holds until external global reset.
module mamc_top
  import mamc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int WDOG_CYCLES = WDOG_CYC,
  parameter int PATTERN_CYCLES = PATTERN_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] function_switch_bank,
  input wire logic logic_reset_button,
  input wire logic park_button,
  input wire logic ext_global_reset,
  input wire logic config_done,
  input wire logic blk_ready,
  output logic blk_valid,
  output mamc_blk_op_s blk_op,
  output mamc_mode_s mode,
  output logic [2:0] test_pattern_sel,
  output logic array_reset_n,
  output logic ready_indicator_led,
  output logic user_led_zero_n,
  output logic user_led_one_n
);

  localparam int NIN = 10;
  localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int WD_W = $clog2(WDOG_CYCLES + 1);
  localparam int PT_W = $clog2(PATTERN_CYCLES + 1);

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_WRITE = 4'h2,
    S_CLOCK = 4'h4,
    S_WAIT = 4'h8
  } mamc_state_e;

  logic [NIN-1:0] raw_in, sync1_reg, sync2_reg, db_in;
  logic [7:0] sw_db, eff_sw;
  logic btn_reset_db, btn_park_db, park_prev_reg;
  logic [2:0] ctrl_reg;
  logic [7:0] override_reg, cmd_reg;
  logic [1:0] led_on_reg;
  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg, rd_word, wmask;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_write, wr_any, rd_hit, wr_hit;
  logic launch, dropped_reg, kick, wdog_fire, app_rst_reg;
  logic [WD_W-1:0] wdog_cnt_reg;
  logic [PT_W-1:0] pat_cnt_reg;
  logic [2:0] pattern_reg;
  mamc_state_e state_reg;
  mamc_op_e cur_op_reg;
  logic cur_global_reg;
  logic [3:0] cur_blk_reg, last_blk_reg, last_idx;
  logic [6:0] rows_sel;
  logic park_latch_reg;
  logic blk_valid_reg;
  mamc_blk_op_s blk_op_reg;
  mamc_mode_s mode_reg;
  logic array_rst_n_reg, ready_reg;

  // Two-stage synchroniser; only the second stage feeds the debouncers
  assign raw_in = {park_button, logic_reset_button, function_switch_bank};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // One debouncer per input: a change must hold for the full window
  for (genvar i = 0; i < NIN; i++)
  begin : g_db
    logic [DB_W-1:0] cnt_reg;
    logic bit_reg;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cnt_reg <= '0;
        bit_reg <= 1'b0;
      end
      else if (sync2_reg[i] == bit_reg)
        cnt_reg <= '0;
      else if (cnt_reg == DB_W'(DEBOUNCE_CYCLES - 1))
      begin
        bit_reg <= sync2_reg[i];
        cnt_reg <= '0;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
    assign db_in[i] = bit_reg;
  end

  assign sw_db = db_in[7:0];
  assign btn_reset_db = db_in[8];
  assign btn_park_db = db_in[9];
  // Host override takes the place of the physical bank
  assign eff_sw = ctrl_reg[CTRL_OVR_EN] ? override_reg : sw_db;

  // Mode controls registered from the effective switch bank
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= '0;
    else
    begin
      mode_reg.park <= eff_sw[SW_PARK] | park_latch_reg;
      mode_reg.halt <= eff_sw[SW_HALT];
      mode_reg.complement <= eff_sw[SW_COMPLEMENT];
      mode_reg.ns_flip <= eff_sw[SW_FLIP];
      mode_reg.reset_type <= mamc_rst_type_e'(eff_sw[SW_RTYPE_LO +: 2]);
      mode_reg.row_addr <= eff_sw[SW_ROW_ADDR];
      mode_reg.wdog_en <= eff_sw[SW_WDOG];
    end
  end
  assign mode = mode_reg;

  // Watchdog: restarts on a kick write or while disabled
  assign kick = do_write && awaddr_reg == OFS_WDOG_KICK && wr_any;
  assign wdog_fire = mode_reg.wdog_en && wdog_cnt_reg == WD_W'(WDOG_CYCLES - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !mode_reg.wdog_en || kick || wdog_fire)
      wdog_cnt_reg <= '0;
    else
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
  end

  // Application reset source: watchdog alone when enabled, else the button
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      app_rst_reg <= 1'b0;
      array_rst_n_reg <= 1'b0;
    end
    else
    begin
      app_rst_reg <= mode_reg.wdog_en ? wdog_fire : btn_reset_db;
      array_rst_n_reg <= !(mode_reg.wdog_en ? wdog_fire : btn_reset_db);
    end
  end
  assign array_reset_n = array_rst_n_reg;

  // Test pattern stepping; halt freezes both prescaler and index
  always_ff @(posedge aclk)
  begin
    if (!aresetn || app_rst_reg)
    begin
      pat_cnt_reg <= '0;
      pattern_reg <= 3'h0;
    end
    else if (!mode_reg.halt)
    begin
      if (pat_cnt_reg == PT_W'(PATTERN_CYCLES - 1))
      begin
        pat_cnt_reg <= '0;
        pattern_reg <= pattern_reg + 3'h1;
      end
      else
        pat_cnt_reg <= pat_cnt_reg + 1'b1;
    end
  end
  assign test_pattern_sel = pattern_reg;

  // Array geometry from the control register
  always_comb
  begin
    last_idx = LAST_BLK_16;
    rows_sel = ROWS_800;
    if (ctrl_reg[CTRL_ATYPE_LO +: 2] == AT_1080)
    begin
      last_idx = LAST_BLK_15;
      rows_sel = ROWS_1080;
    end
    else if (ctrl_reg[CTRL_ATYPE_LO +: 2] == AT_768)
      rows_sel = ROWS_768;
  end

  // AXI write channels are taken independently, answered once both are in
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_any = |wstrb_reg;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_hit = awaddr_reg == OFS_CTRL || awaddr_reg == OFS_OVERRIDE || awaddr_reg == OFS_CMD ||
                  awaddr_reg == OFS_STATUS || awaddr_reg == OFS_WDOG_KICK || awaddr_reg == OFS_LED;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Software-owned registers, byte-lane masked except the command register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= CTRL_RESET;
      override_reg <= OVERRIDE_RESET;
      cmd_reg <= CMD_RESET;
      led_on_reg <= LED_ON_RESET;
    end
    else if (do_write)
    begin
      if (awaddr_reg == OFS_CTRL)
        ctrl_reg <= (ctrl_reg & ~wmask[2:0]) | (wdata_reg[2:0] & wmask[2:0]);
      if (awaddr_reg == OFS_OVERRIDE)
        override_reg <= (override_reg & ~wmask[7:0]) | (wdata_reg[7:0] & wmask[7:0]);
      if (launch)
        cmd_reg <= wdata_reg[7:0];
      if (awaddr_reg == OFS_LED)
        led_on_reg <= (led_on_reg & ~wmask[1:0]) | (wdata_reg[1:0] & wmask[1:0]);
    end
  end

  // A command write starts only when idle; otherwise it is dropped
  assign launch = do_write && awaddr_reg == OFS_CMD && wr_any && state_reg == S_IDLE && !app_rst_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dropped_reg <= 1'b0;
    else if (do_write && awaddr_reg == OFS_CMD && wr_any && !launch)
      dropped_reg <= 1'b1;
    else if (do_write && awaddr_reg == OFS_STATUS && wmask[STAT_DROPPED] && wdata_reg[STAT_DROPPED])
      dropped_reg <= 1'b0;
  end

  // Read path: one cycle from address to data
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      OFS_CTRL: rd_word[2:0] = ctrl_reg;
      OFS_OVERRIDE: rd_word[7:0] = override_reg;
      OFS_CMD: rd_word[7:0] = cmd_reg;
      OFS_STATUS: rd_word[11:0] = {dropped_reg, mode_reg.park, state_reg == S_WAIT, state_reg != S_IDLE, eff_sw};
      OFS_WDOG_KICK: rd_word = 32'h0000_0000;
      OFS_LED: rd_word[1:0] = led_on_reg;
      default: rd_hit = 1'b0;
    endcase
  end
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Park latch: a button press sets it regardless of activity; set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      park_prev_reg <= 1'b0;
      park_latch_reg <= 1'b0;
    end
    else
    begin
      park_prev_reg <= btn_park_db;
      if (btn_park_db && !park_prev_reg)
        park_latch_reg <= 1'b1;
      else if (launch && wdata_reg[2:0] == OP_FLOAT)
        park_latch_reg <= 1'b1;
      else if (launch || app_rst_reg)
        park_latch_reg <= 1'b0;
    end
  end

  // Command sequencer: block writes or clears, then an optional mirror clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || app_rst_reg)
    begin
      state_reg <= S_IDLE;
      cur_op_reg <= OP_NONE;
      cur_global_reg <= 1'b0;
      cur_blk_reg <= 4'h0;
      last_blk_reg <= 4'h0;
      blk_valid_reg <= 1'b0;
      blk_op_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (launch)
          begin
            cur_op_reg <= mamc_op_e'(wdata_reg[2:0]);
            cur_global_reg <= wdata_reg[3];
            // Whole image walks every block, else just the one
            cur_blk_reg <= wdata_reg[3] ? 4'h0 : wdata_reg[7:4];
            last_blk_reg <= wdata_reg[3] ? last_idx : wdata_reg[7:4];
            blk_op_reg.global <= wdata_reg[3];
            blk_op_reg.block <= wdata_reg[3] ? 4'h0 : wdata_reg[7:4];
            blk_op_reg.rows <= rows_sel;
            unique case (mamc_op_e'(wdata_reg[2:0]))
              OP_LOAD, OP_LOAD_RESET, OP_CLEAR, OP_CLEAR_RESET:
              begin
                state_reg <= S_WRITE;
                blk_valid_reg <= 1'b1;
                blk_op_reg.write_data <= !wdata_reg[2];
                blk_op_reg.clear_data <= wdata_reg[2];
                blk_op_reg.mirror_clock <= 1'b0;
              end
              OP_RESET:
              begin
                state_reg <= S_CLOCK;
                blk_valid_reg <= 1'b1;
                blk_op_reg.write_data <= 1'b0;
                blk_op_reg.clear_data <= 1'b0;
                blk_op_reg.mirror_clock <= 1'b1;
              end
              OP_WAIT_EXT: state_reg <= S_WAIT;
              OP_NONE, OP_FLOAT: state_reg <= S_IDLE;
            endcase
          end
        end
        S_WRITE:
        begin
          if (blk_ready)
          begin
            if (cur_blk_reg != last_blk_reg)
            begin
              cur_blk_reg <= cur_blk_reg + 4'h1;
              blk_op_reg.block <= cur_blk_reg + 4'h1;
            end
            else if (cur_op_reg == OP_LOAD_RESET || cur_op_reg == OP_CLEAR_RESET)
            begin
              // Display what was just stored
              state_reg <= S_CLOCK;
              blk_op_reg.write_data <= 1'b0;
              blk_op_reg.clear_data <= 1'b0;
              blk_op_reg.mirror_clock <= 1'b1;
              blk_op_reg.block <= cur_global_reg ? 4'h0 : last_blk_reg;
            end
            else
            begin
              state_reg <= S_IDLE;
              blk_valid_reg <= 1'b0;
            end
          end
        end
        S_CLOCK:
        begin
          if (blk_ready)
          begin
            state_reg <= S_IDLE;
            blk_valid_reg <= 1'b0;
            blk_op_reg.mirror_clock <= 1'b0;
          end
        end
        S_WAIT:
        begin
          if (ext_global_reset)
            state_reg <= S_IDLE;
        end
      endcase
    end
  end
  assign blk_valid = blk_valid_reg;
  assign blk_op = blk_op_reg;

  // LEDs: ready is active high, user LEDs active low and dark after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ready_reg <= 1'b0;
    else
      ready_reg <= config_done;
  end
  assign ready_indicator_led = ready_reg;
  assign user_led_zero_n = !led_on_reg[0];
  assign user_led_one_n = !led_on_reg[1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_last_write;
    !app_rst_reg && state_reg == S_WRITE && blk_ready && cur_blk_reg == last_blk_reg &&
      (cur_op_reg == OP_LOAD_RESET || cur_op_reg == OP_CLEAR_RESET);
  endsequence
  sequence seq_clock_issue;
    state_reg == S_CLOCK && blk_valid && blk_op.mirror_clock && !blk_op.write_data;
  endsequence

  chk_park_follow: assert property ($rose(eff_sw[SW_PARK]) |=> mode.park)
    else $error("park switch did not park mirrors");
  chk_halt_freeze: assert property (mode.halt && !app_rst_reg |=> $stable(test_pattern_sel))
    else $error("pattern moved while halted");
  chk_complement_flip: assert property (##1 mode.complement == $past(eff_sw[SW_COMPLEMENT]) &&
    mode.ns_flip == $past(eff_sw[SW_FLIP]))
    else $error("complement or flip mode wrong");
  chk_reset_type: assert property (##1 mode.reset_type == mamc_rst_type_e'($past(eff_sw[5:4])))
    else $error("reset type code wrong");
  chk_row_wdog: assert property (##1 mode.row_addr == $past(eff_sw[SW_ROW_ADDR]) &&
    mode.wdog_en == $past(eff_sw[SW_WDOG]))
    else $error("row address or watchdog mode wrong");
  chk_wdog_blocks_btn: assert property (mode.wdog_en && btn_reset_db && !wdog_fire |=> array_reset_n)
    else $error("button reset passed while watchdog on");
  chk_btn_reset: assert property (!mode.wdog_en && btn_reset_db |=> !array_reset_n ##0 app_rst_reg)
    else $error("button reset not propagated");
  chk_park_press: assert property (btn_park_db && !park_prev_reg |=> ##1 mode.park)
    else $error("park press ignored");
  chk_ready_led: assert property (config_done |=> ready_indicator_led)
    else $error("ready led not lit");
  chk_load_no_clock: assert property (cur_op_reg == OP_LOAD && state_reg == S_WRITE |-> !blk_op.mirror_clock)
    else $error("load disturbed mirrors");
  chk_load_then_show: assert property (seq_last_write |=> seq_clock_issue)
    else $error("mirror clock missing after load or clear");
  chk_wait_hold: assert property (state_reg == S_WAIT && !ext_global_reset && !app_rst_reg |=> state_reg == S_WAIT)
    else $error("wait left without external reset");

endmodule // mamc_top

// File: bench/mamc_array_model.sv
// Behavioural mirror-array controller on the block link.
// Assumes the sender holds blk_op steady until valid and ready meet.
`timescale 1ns/1ps
module mamc_array_model
  import mamc_pkg::*;
(
  input wire logic aclk,
  input wire logic blk_valid,
  input wire mamc_blk_op_s blk_op,
  output logic blk_ready
);
  int n_wr = 0;
  int n_clr = 0;
  int n_clk = 0;
  mamc_blk_op_s data_op = '0;
  logic tick = 1'b0;
  // Ready on alternate cycles, so an op can wait one cycle before it is taken
  assign blk_ready = tick;
  // Tally accepted ops by kind and keep the last data op
  always @(posedge aclk)
  begin
    tick <= ~tick;
    if (blk_valid && blk_ready)
    begin
      n_wr <= n_wr + int'(blk_op.write_data);
      n_clr <= n_clr + int'(blk_op.clear_data);
      n_clk <= n_clk + int'(blk_op.mirror_clock);
      if (blk_op.write_data || blk_op.clear_data)
        data_op <= blk_op;
    end
  end
endmodule // mamc_array_model

// File: bench/mirror_array_mode_control_bench.sv
// Self-checking bench for the mirror-array mode control block.
// Assumes short debounce, watchdog and pattern counts set here.
`timescale 1ns/1ps
module mirror_array_mode_control_bench;
  import mamc_pkg::*;
  localparam int LAG = 12; // Sync, debounce and mode register, with margin
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, sw = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rst_btn = 1'b0, park_btn = 1'b0, ext_rst = 1'b0, cfg_done = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, blk_ready, blk_valid, arr_rst_n, rdy_led, led0_n, led1_n;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0] pat, p;
  mamc_blk_op_s blk_op;
  mamc_mode_s mode;
  int mismatches = 0, cmp_count = 0, cycles = 0, t, k, n;
  logic g;
  mamc_op_e op;
  mamc_op_e ops[5] = '{OP_LOAD, OP_LOAD_RESET, OP_RESET, OP_CLEAR, OP_CLEAR_RESET};
  logic [6:0] rows[3] = '{7'h48, 7'h30, 7'h32};
  logic [7:0] vec[8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h40};

  always #10 aclk = ~aclk;

  mamc_top #(.DEBOUNCE_CYCLES(4), .WDOG_CYCLES(64), .PATTERN_CYCLES(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .function_switch_bank(sw), .logic_reset_button(rst_btn), .park_button(park_btn),
    .ext_global_reset(ext_rst), .config_done(cfg_done), .blk_ready(blk_ready), .blk_valid(blk_valid),
    .blk_op(blk_op), .mode(mode), .test_pattern_sel(pat), .array_reset_n(arr_rst_n),
    .ready_indicator_led(rdy_led), .user_led_zero_n(led0_n), .user_led_one_n(led1_n));

  mamc_array_model u_arr (.aclk(aclk), .blk_valid(blk_valid), .blk_op(blk_op), .blk_ready(blk_ready));

  // Switch bank to mode struct: park, halt, complement, flip, type, row, watchdog
  function automatic logic [7:0] mode_of(input logic [7:0] s);
    return {s[0], s[1], s[2], s[3], s[5], s[4], s[6], s[7]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Handshakes are judged at the negedge, where ready is already what the next edge samples
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      if (tb)
        rs = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
    end
    while (!tb);
    @(negedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rready && rvalid;
      if (tr)
      begin
        v = rdata;
        rs = rresp;
      end
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
    end
    while (!tr);
    @(negedge aclk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the sequence needs
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    settle(10);
    @(posedge aclk) aresetn <= 1'b1;
    axi_rd(OFS_CTRL, d, r);
    chk(rdy_led, 0);
    chk(d, 0);
    axi_wr(8'h40, 1, r);
    chk(r, RESP_SLVERR);
    axi_rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(OFS_LED, 1, r);
    chk({led1_n, led0_n}, 2'h2);
    @(posedge aclk) cfg_done <= 1'b1;
    settle(3);
    chk(rdy_led, 1);
    foreach (vec[i])
    begin
      @(posedge aclk) sw <= vec[i];
      settle(LAG);
      chk(mode, mode_of(vec[i]));
    end
    @(posedge aclk) sw <= 8'h02;
    settle(LAG);
    p = pat;
    settle(20);
    chk(pat, p);
    @(posedge aclk) sw <= 8'h00;
    settle(LAG + 10);
    chk(pat != p, 1);
    axi_wr(OFS_CTRL, 1, r);
    axi_wr(OFS_OVERRIDE, 8'h0C, r);
    settle(3);
    chk(mode, mode_of(8'h0C));
    // Each op once, alternating single and whole-image over the array types
    for (int i = 0; i < 5; i++)
    begin
      t = i % 3;
      g = i[0];
      op = ops[i];
      k = g ? ((t == 0) ? 15 : 16) : 1;
      axi_wr(OFS_CTRL, {29'h0, t[1:0], 1'b0}, r);
      u_arr.n_wr = 0;
      u_arr.n_clr = 0;
      u_arr.n_clk = 0;
      axi_wr(OFS_CMD, {24'h0, 4'h5, g, op}, r);
      do axi_rd(OFS_STATUS, d, r); while (d[STAT_BUSY] !== 1'b0);
      chk(u_arr.n_wr, (op == OP_LOAD || op == OP_LOAD_RESET) ? k : 0);
      chk(u_arr.n_clr, (op == OP_CLEAR || op == OP_CLEAR_RESET) ? k : 0);
      chk(u_arr.n_clk, (op == OP_LOAD || op == OP_CLEAR) ? 0 : 1);
      if (op != OP_RESET)
      begin
        chk(u_arr.data_op.rows, rows[t]);
        chk(u_arr.data_op.block, g ? k - 1 : 5);
        chk(u_arr.data_op.global, g);
      end
    end
    axi_wr(OFS_CMD, {29'h0, OP_WAIT_EXT}, r);
    settle(8);
    axi_rd(OFS_STATUS, d, r);
    chk(d[STAT_WAIT], 1);
    @(posedge aclk) ext_rst <= 1'b1;
    settle(3);
    axi_rd(OFS_STATUS, d, r);
    chk(d[STAT_BUSY], 0);
    // Float command parks; the next launched command lets go again
    axi_wr(OFS_CMD, {29'h0, OP_FLOAT}, r);
    chk(mode.park, 1);
    axi_wr(OFS_CMD, 32'h0000_0000, r);
    chk(mode.park, 0);
    @(posedge aclk) park_btn <= 1'b1;
    settle(LAG);
    @(posedge aclk) park_btn <= 1'b0;
    settle(3);
    chk(mode.park, 1);
    @(posedge aclk) rst_btn <= 1'b1;
    settle(LAG);
    chk(arr_rst_n, 0);
    @(posedge aclk) rst_btn <= 1'b0;
    settle(LAG);
    chk(arr_rst_n, 1);
    @(posedge aclk) sw <= 8'h80;
    settle(LAG);
    chk(mode, mode_of(8'h80));
    @(posedge aclk) rst_btn <= 1'b1;
    n = 0;
    repeat (150)
    begin
      @(negedge aclk);
      n += int'(arr_rst_n === 1'b0);
    end
    chk(n >= 1 && n <= 3, 1);
    wrap_up();
  end
endmodule // mirror_array_mode_control_bench
